// ===== pkg/irsc_map.svh
`ifndef IRSC_MAP_SVH
`define IRSC_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IRSC_OFF_CTRL    12'h000
`define IRSC_OFF_STATUS  12'h004
`define IRSC_OFF_CLEAR   12'h008
`define IRSC_OFF_ENABLE  12'h00C
`define IRSC_OFF_RELOAD  12'h010
`define IRSC_OFF_BUS     12'h014

// ----------------------------------------------------------------
// Control fields (bit positions)
// ----------------------------------------------------------------
`define IRSC_CTRL_RESTART 0
`define IRSC_CTRL_STOP    1
`define IRSC_CTRL_SDIE    2
`define IRSC_CTRL_PDIE    3
`define IRSC_CTRL_NATIVE  4

// ----------------------------------------------------------------
// Status, clear and enable fields (bit positions)
// ----------------------------------------------------------------
`define IRSC_ST_START  0
`define IRSC_ST_STOP   1
`define IRSC_ST_COLL   2
`define IRSC_ST_RSDONE 3
`define IRSC_ST_SPDONE 4

// ----------------------------------------------------------------
// Bus view fields and reset values
// ----------------------------------------------------------------
`define IRSC_BUS_STATE_LSB 4
`define IRSC_RST_CTRL    5'h00
`define IRSC_RST_ENABLE  5'h00
`define IRSC_RST_RELOAD  8'h10
`define IRSC_RST_SYNC    2'h3

`endif

// ===== pkg/irsc_pkg.sv
package irsc_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int RLD_W  = 8;
	localparam int NEV    = 5;

	// ------------------------------------------------------------
	// Sequencer states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_RS_REL  = 9'h002,
		ST_RS_SCLH = 9'h004,
		ST_RS_CNT  = 9'h008,
		ST_RS_HOLD = 9'h010,
		ST_SP_SDAL = 9'h020,
		ST_SP_SCLH = 9'h040,
		ST_SP_CNT1 = 9'h080,
		ST_SP_CNT2 = 9'h100
	} irsc_state_t;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} irsc_apb_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic              pready;
		logic              pslverr;
	} irsc_apb_rsp_t;

	typedef struct packed {
		logic scl_i;
		logic sda_i;
	} irsc_pad_in_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} irsc_pad_out_t;

	// ------------------------------------------------------------
	// Module state
	// ------------------------------------------------------------
	typedef struct packed {
		irsc_state_t       st;
		logic              scl_drv;
		logic              sda_drv;
		logic [1:0]        scl_sy;
		logic [1:0]        sda_sy;
		logic              scl_p;
		logic              sda_p;
		logic              seen_low;
		logic [4:0]        ctrl;
		logic [NEV-1:0]    status;
		logic [NEV-1:0]    irq_en;
		logic [RLD_W-1:0]  reload;
		logic [DATA_W-1:0] prdata;
		logic              pslverr;
	} irsc_regs_t;

	typedef struct packed {
		logic [RLD_W-1:0] cnt;
		logic             run;
	} irsc_baud_t;

endpackage : irsc_pkg

// ===== rtl/irsc_baud.sv
`timescale 1ns/10ps
`include "irsc_map.svh"

module irsc_baud (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    load,
	input  wire logic [irsc_pkg::RLD_W-1:0] reload,
	output logic                         expired
);
	import irsc_pkg::*;

	irsc_baud_t q;
	irsc_baud_t d;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Down counter
	// ------------------------------------------------------------
	// Load wins over counting; one step per clock, stops at zero
	always_comb begin
		d = q;
		if (load) begin
			d.cnt = reload;
			d.run = 1'b1;
		end else if (q.run) begin
			if (q.cnt == '0)
				d.run = 1'b0;
			else
				d.cnt = q.cnt - 8'h01;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			q <= '0;
		else
			q <= d;
	end

	// One-cycle expiry pulse at zero
	assign expired = q.run && (q.cnt == '0);

	a_tmr_load: assert property (load |=> q.run && q.cnt == $past(reload))
		else $error("timer did not take the reload value");
	a_tmr_step: assert property (q.run && q.cnt != '0 && !load
		|=> q.cnt == $past(q.cnt) - 8'h01)
		else $error("timer did not step down by one");

endmodule : irsc_baud

// ===== rtl/irsc_seq.sv
// Operation
// - enabled start/stop detect bits raise interrupts in non-native modes
// - in native interrupting mode the two enable bits change nothing
// - repeated start collides if SDA is low when SCL rises
// - repeated start collides if SCL falls before SDA is driven low
// - after SDA release, count reload, free SCL, sample SDA on SCL high
// - SDA high means reload and count again; SDA falling is no collision
// - SCL falling during second count before SDA drive is a collision
// - both lines high at expiry: drive SDA low, reload the timer
// - at final expiry drive SCL low regardless and finish
// - stop begins with SDA low, then SCL is released
// - stop waits for SCL high, then counts reload before sampling SDA
// - stop collides if released SDA samples low after expiry
// - stop collides if released SCL samples low before SDA rises
// - start is SDA falling, stop SDA rising, both with SCL high
// - stop valid only after an SCL low period since the last start
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`include "irsc_map.svh"

module irsc_seq (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire irsc_pkg::irsc_apb_req_t apb_req,
	output irsc_pkg::irsc_apb_rsp_t      apb_rsp,
	input  wire irsc_pkg::irsc_pad_in_t  pad_in,
	output irsc_pkg::irsc_pad_out_t      pad_out,
	output logic                        irq
);
	import irsc_pkg::*;

	irsc_regs_t       q;
	irsc_regs_t       d;
	logic             tmr_load;
	logic             tmr_exp;
	logic             coll;
	logic             rs_done;
	logic             sp_done;
	logic             scl_s;
	logic             sda_s;
	logic             start_det;
	logic             stop_det;
	logic             wr_en;
	logic             setup;
	logic [NEV-1:0]   ev;
	logic [NEV-1:0]   clr;
	logic [DATA_W-1:0] rd_val;
	logic             mapped;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Address match, shared by read and write decode
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction : hit

	// ------------------------------------------------------------
	// Baud timer
	// ------------------------------------------------------------
	irsc_baud u_baud (
		.clk     (clk),
		.rst     (rst),
		.load    (tmr_load),
		.reload  (q.reload),
		.expired (tmr_exp)
	);

	// ------------------------------------------------------------
	// Line view and condition detect
	// ------------------------------------------------------------
	// Second synchroniser stage is the only view of the lines
	assign scl_s = q.scl_sy[1];
	assign sda_s = q.sda_sy[1];
	// SDA edges while SCL stays high
	assign start_det = scl_s && q.scl_p && q.sda_p && !sda_s;
	assign stop_det  = scl_s && q.scl_p && !q.sda_p && sda_s
		&& q.seen_low;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign setup = apb_req.psel && !apb_req.penable;
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign clr = (wr_en && hit(apb_req.paddr, `IRSC_OFF_CLEAR))
		? apb_req.pwdata[NEV-1:0] : '0;

	// Read value and map check for the setup phase
	always_comb begin
		rd_val = '0;
		mapped = 1'b1;
		if (hit(apb_req.paddr, `IRSC_OFF_CTRL)) begin
			rd_val[4:0] = q.ctrl;
		end else if (hit(apb_req.paddr, `IRSC_OFF_STATUS)) begin
			rd_val[NEV-1:0] = q.status;
		end else if (hit(apb_req.paddr, `IRSC_OFF_CLEAR)) begin
			rd_val = '0;
		end else if (hit(apb_req.paddr, `IRSC_OFF_ENABLE)) begin
			rd_val[NEV-1:0] = q.irq_en;
		end else if (hit(apb_req.paddr, `IRSC_OFF_RELOAD)) begin
			rd_val[RLD_W-1:0] = q.reload;
		end else if (hit(apb_req.paddr, `IRSC_OFF_BUS)) begin
			rd_val[3:0] = {q.sda_drv, q.scl_drv, sda_s, scl_s};
			rd_val[`IRSC_BUS_STATE_LSB +: 9] = q.st;
		end else begin
			mapped = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		d        = q;
		tmr_load = 1'b0;
		coll     = 1'b0;
		rs_done  = 1'b0;
		sp_done  = 1'b0;
		ev       = '0;
		// Two-stage synchronisers and previous samples
		d.scl_sy = {q.scl_sy[0], pad_in.scl_i};
		d.sda_sy = {q.sda_sy[0], pad_in.sda_i};
		d.scl_p  = scl_s;
		d.sda_p  = sda_s;
		// An SCL low period arms stop detection; start disarms it
		if (start_det || stop_det)
			d.seen_low = 1'b0;
		else if (!scl_s)
			d.seen_low = 1'b1;
		// Sequencer
		case (q.st)
			ST_IDLE: begin
				if (wr_en && hit(apb_req.paddr, `IRSC_OFF_CTRL)
					&& apb_req.pwdata[`IRSC_CTRL_RESTART]) begin
					d.st     = ST_RS_REL;
					d.sda_drv = 1'b0;
					tmr_load = 1'b1;
				end else if (wr_en && hit(apb_req.paddr, `IRSC_OFF_CTRL)
					&& apb_req.pwdata[`IRSC_CTRL_STOP]) begin
					d.st      = ST_SP_SDAL;
					d.sda_drv = 1'b1;
					d.scl_drv = 1'b1;
				end
			end
			ST_RS_REL: begin
				if (tmr_exp) begin
					d.st      = ST_RS_SCLH;
					d.scl_drv = 1'b0;
				end
			end
			ST_RS_SCLH: begin
				if (scl_s) begin
					if (!sda_s) begin
						coll = 1'b1;
					end else begin
						d.st     = ST_RS_CNT;
						tmr_load = 1'b1;
					end
				end
			end
			ST_RS_CNT: begin
				// SDA falling here is ignored; SCL falling is not
				if (!scl_s) begin
					coll = 1'b1;
				end else if (tmr_exp) begin
					d.st      = ST_RS_HOLD;
					d.sda_drv = 1'b1;
					tmr_load  = 1'b1;
				end
			end
			ST_RS_HOLD: begin
				if (tmr_exp) begin
					d.st      = ST_IDLE;
					d.scl_drv = 1'b1;
					rs_done   = 1'b1;
				end
			end
			ST_SP_SDAL: begin
				if (!sda_s) begin
					d.st      = ST_SP_SCLH;
					d.scl_drv = 1'b0;
				end
			end
			ST_SP_SCLH: begin
				// Waiting here honours clock stretching
				if (scl_s) begin
					d.st     = ST_SP_CNT1;
					tmr_load = 1'b1;
				end
			end
			ST_SP_CNT1: begin
				if (!scl_s) begin
					coll = 1'b1;
				end else if (tmr_exp) begin
					d.st      = ST_SP_CNT2;
					d.sda_drv = 1'b0;
					tmr_load  = 1'b1;
				end
			end
			ST_SP_CNT2: begin
				if (!scl_s && !sda_s) begin
					coll = 1'b1;
				end else if (tmr_exp) begin
					if (!sda_s) begin
						coll = 1'b1;
					end else begin
						d.st    = ST_IDLE;
						sp_done = 1'b1;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
		// Collision abandons the sequence and frees both lines
		if (coll) begin
			d.st      = ST_IDLE;
			d.scl_drv = 1'b0;
			d.sda_drv = 1'b0;
		end
		// Events; native mode interrupts on start and stop anyway
		ev[`IRSC_ST_START] = start_det && (q.ctrl[`IRSC_CTRL_NATIVE]
			|| q.ctrl[`IRSC_CTRL_SDIE]);
		ev[`IRSC_ST_STOP] = stop_det && (q.ctrl[`IRSC_CTRL_NATIVE]
			|| q.ctrl[`IRSC_CTRL_PDIE]);
		ev[`IRSC_ST_COLL]   = coll;
		ev[`IRSC_ST_RSDONE] = rs_done;
		ev[`IRSC_ST_SPDONE] = sp_done;
		// Sticky status; a new event wins over a clear
		for (int i = 0; i < NEV; i++)
			d.status[i] = ev[i] || (q.status[i] && !clr[i]);
		// Register writes
		if (wr_en) begin
			if (hit(apb_req.paddr, `IRSC_OFF_CTRL)) begin
				d.ctrl = apb_req.pwdata[4:0];
				d.ctrl[`IRSC_CTRL_RESTART] = 1'b0;
				d.ctrl[`IRSC_CTRL_STOP]    = 1'b0;
			end else if (hit(apb_req.paddr, `IRSC_OFF_ENABLE)) begin
				d.irq_en = apb_req.pwdata[NEV-1:0];
			end else if (hit(apb_req.paddr, `IRSC_OFF_RELOAD)) begin
				d.reload = apb_req.pwdata[RLD_W-1:0];
			end
		end
		// Read data and error captured in the setup phase
		if (setup) begin
			d.prdata  = rd_val;
			d.pslverr = !mapped;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q        <= '0;
			q.st     <= ST_IDLE;
			q.scl_sy <= `IRSC_RST_SYNC;
			q.sda_sy <= `IRSC_RST_SYNC;
			q.scl_p  <= 1'b1;
			q.sda_p  <= 1'b1;
			q.ctrl   <= `IRSC_RST_CTRL;
			q.irq_en <= `IRSC_RST_ENABLE;
			q.reload <= `IRSC_RST_RELOAD;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Open-drain pads: enable pulls the line low
	assign pad_out.scl_o   = 1'b0;
	assign pad_out.scl_oe  = q.scl_drv;
	assign pad_out.sda_o   = 1'b0;
	assign pad_out.sda_oe  = q.sda_drv;
	assign apb_rsp.prdata  = q.prdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = q.pslverr;
	assign irq = |(q.status & q.irq_en);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_abandon;
		q.st == ST_IDLE && q.status[`IRSC_ST_COLL]
			&& !q.scl_drv && !q.sda_drv;
	endsequence

	sequence s_rs_sample_low;
		q.st == ST_RS_SCLH && scl_s && !sda_s;
	endsequence

	a_rs_low_sda: assert property (s_rs_sample_low |=> s_abandon)
		else $error("repeated start missed SDA low collision");
	a_rs_scl_fall: assert property (q.st == ST_RS_CNT && !scl_s
		|=> s_abandon)
		else $error("repeated start missed SCL fall");
	a_rs_drive_sda: assert property (q.st == ST_RS_CNT && scl_s
		&& sda_s && tmr_exp |=> q.st == ST_RS_HOLD && pad_out.sda_oe
		&& u_baud.q.cnt == q.reload)
		else $error("SDA not driven low at expiry");
	a_rs_finish: assert property (q.st == ST_RS_HOLD && tmr_exp
		|=> q.st == ST_IDLE && pad_out.scl_oe && pad_out.sda_oe
		&& q.status[`IRSC_ST_RSDONE])
		else $error("repeated start did not finish");
	a_sp_free_scl: assert property (q.st == ST_SP_SDAL && !sda_s
		|=> !pad_out.scl_oe && pad_out.sda_oe)
		else $error("stop did not release SCL");
	a_sp_late_sda: assert property (q.st == ST_SP_CNT2 && tmr_exp
		&& scl_s && !sda_s |=> s_abandon)
		else $error("stop missed SDA low collision");
	a_sp_scl_low: assert property ((q.st == ST_SP_CNT1 || (q.st ==
		ST_SP_CNT2 && !sda_s)) && !scl_s |=> s_abandon)
		else $error("stop missed SCL low collision");
	a_stop_armed: assert property ($rose(sda_s) && scl_s && $past(scl_s)
		&& !q.seen_low && q.ctrl[`IRSC_CTRL_PDIE]
		&& !q.status[`IRSC_ST_STOP] |=> !q.status[`IRSC_ST_STOP])
		else $error("stop detected without SCL low");
	a_start_seen: assert property ($fell(sda_s) && scl_s && $past(scl_s)
		&& q.ctrl[`IRSC_CTRL_NATIVE] |=> q.status[`IRSC_ST_START])
		else $error("start condition not detected");
	// Timer reloads when each counted phase begins
	a_rs_reload: assert property (q.st == ST_RS_SCLH && scl_s && sda_s
		|=> q.st == ST_RS_CNT && u_baud.q.cnt == q.reload)
		else $error("repeated start did not reload");
	a_sp_count: assert property (q.st == ST_SP_SCLH && scl_s
		|=> q.st == ST_SP_CNT1 && u_baud.q.cnt == q.reload)
		else $error("stop did not load the timer");
	a_sp_free_sda: assert property (q.st == ST_SP_CNT1 && scl_s && tmr_exp
		|=> q.st == ST_SP_CNT2 && !pad_out.sda_oe)
		else $error("stop did not release SDA");
	a_start_irq: assert property (start_det && q.ctrl[`IRSC_CTRL_SDIE]
		|=> q.status[`IRSC_ST_START])
		else $error("start detect did not flag");
	a_native_irq: assert property (stop_det && q.ctrl[`IRSC_CTRL_NATIVE]
		|=> q.status[`IRSC_ST_STOP])
		else $error("native mode stop did not flag");

endmodule : irsc_seq

// ===== dv/irsc_bus_model.sv
`timescale 1ns/10ps

module irsc_bus_model (
	input  wire logic                    hold_scl,
	input  wire logic                    hold_sda,
	input  wire irsc_pkg::irsc_pad_out_t pad_out,
	output irsc_pkg::irsc_pad_in_t       pad_in
);
	import irsc_pkg::*;

	logic lclk;
	logic scl_pull;
	logic sda_pull;

	// Far master runs on its own unrelated clock
	initial begin
		lclk = 1'b0;
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	always #62.5 lclk = ~lclk;

	// Pull requests take effect only on the far clock
	always @(posedge lclk) begin
		scl_pull <= hold_scl;
		sda_pull <= hold_sda;
	end

	// Open-drain lines with pull-ups: low if anyone pulls
	assign pad_in.scl_i = ~((pad_out.scl_oe & ~pad_out.scl_o) | scl_pull);
	assign pad_in.sda_i = ~((pad_out.sda_oe & ~pad_out.sda_o) | sda_pull);
endmodule : irsc_bus_model

// ===== dv/testbench.sv
`timescale 1ns/10ps
`include "irsc_map.svh"

module testbench;
	import irsc_pkg::*;

	logic          clk;
	logic          rst;
	irsc_apb_req_t apb_req;
	irsc_apb_rsp_t apb_rsp;
	irsc_pad_in_t  pad_in;
	irsc_pad_out_t pad_out;
	logic          irq;
	logic          hold_scl;
	logic          hold_sda;
	logic [31:0]   rd;
	logic          err;
	int            fails;
	int            total_checks;
	int            cycles;

	// Sequence table: command, far SDA hold, far SCL dip, status
	logic [4:0] t_ctrl [0:11] = '{5'h0D, 5'h0E, 5'h01, 5'h02, 5'h11,
		5'h12, 5'h0D, 5'h0D, 5'h0D, 5'h0E, 5'h0D, 5'h0E};
	logic       t_sda  [0:11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	int         t_dip  [0:11] = '{0, 0, 0, 0, 0, 0, 0, 25, 0, 0, 0, 10};
	logic [4:0] t_exp  [0:11] = '{5'h09, 5'h12, 5'h08, 5'h10, 5'h09,
		5'h12, 5'h04, 5'h04, 5'h09, 5'h04, 5'h09, 5'h04};

	irsc_seq irsc_seq_inst (
		.clk     (clk),
		.rst     (rst),
		.apb_req (apb_req),
		.apb_rsp (apb_rsp),
		.pad_in  (pad_in),
		.pad_out (pad_out),
		.irq     (irq)
	);

	irsc_bus_model irsc_bus_model_inst (
		.hold_scl (hold_scl),
		.hold_sda (hold_sda),
		.pad_out  (pad_out),
		.pad_in   (pad_in)
	);

	// Clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge clk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= a;
		apb_req.pwdata <= wd;
		@(posedge clk);
		apb_req.penable <= 1'b1;
		do @(posedge clk); while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask : apb

	// Run one table entry, then release lines and clear status
	task automatic run_seq(input int i);
		int n;
		if (t_ctrl[i][0]) begin
			hold_scl <= 1'b1;
			repeat (20) @(posedge clk);
		end
		apb(1'b1, `IRSC_OFF_CTRL, {27'h0, t_ctrl[i]});
		hold_sda <= t_sda[i];
		if (t_ctrl[i][0]) begin
			repeat (60) @(posedge clk);
			hold_scl <= 1'b0;
		end
		if (t_dip[i] != 0) begin
			repeat (t_dip[i]) @(posedge clk);
			hold_scl <= 1'b1;
		end
		n = 0;
		rd = 32'h0000_0000;
		while (rd[4] !== 1'b1 && n < 400) begin
			apb(1'b0, `IRSC_OFF_BUS, 32'h0000_0000);
			n++;
		end
		apb(1'b0, `IRSC_OFF_STATUS, 32'h0000_0000);
		chk(rd, {27'h0, t_exp[i]});
		@(negedge clk);
		chk(irq, t_exp[i][3]);
		chk({pad_out.scl_oe, pad_out.sda_oe}, t_exp[i][3] ? 2'h3 : 2'h0);
		hold_scl <= 1'b0;
		hold_sda <= 1'b0;
		repeat (40) @(posedge clk);
		apb(1'b1, `IRSC_OFF_CLEAR, 32'h0000_001F);
		apb(1'b0, `IRSC_OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		@(negedge clk);
		chk(irq, 1'b0);
		$display("test %0d done", i);
	endtask : run_seq

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		apb_req = '0;
		hold_scl = 1'b0;
		hold_sda = 1'b0;
		fails = 0;
		total_checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b0, `IRSC_OFF_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, `IRSC_OFF_ENABLE, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, `IRSC_OFF_RELOAD, 32'h0000_0000);
		chk(rd, 32'h0000_0010);
		apb(1'b0, 12'h018, 32'h0000_0000);
		chk(err, 1'b1);
		apb(1'b1, `IRSC_OFF_RELOAD, 32'h0000_0020);
		apb(1'b0, `IRSC_OFF_RELOAD, 32'h0000_0000);
		chk(rd, 32'h0000_0020);
		apb(1'b1, `IRSC_OFF_ENABLE, 32'h0000_0008);
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			run_seq(i);
		end
		stop_test();
	end
endmodule : testbench
